// ===== rtl/rfpc_pkg.sv
// Constants, types and register map of the protocol configuration block.
// Assumes a host-side register port on the same clock as this block.
package rfpc_pkg;
  localparam logic [4:0] RFPC_ADR_CHIP = 5'h00;
  localparam logic [4:0] RFPC_ADR_PROT = 5'h01;
  localparam logic [4:0] RFPC_ADR_HBR  = 5'h03;
  localparam logic [4:0] RFPC_ADR_PULS = 5'h06;
  localparam logic [4:0] RFPC_ADR_MOD  = 5'h09;
  localparam logic [4:0] RFPC_ADR_LVL  = 5'h0f;
  localparam logic [4:0] RFPC_CMD_INT  = 5'h18;
  localparam logic [4:0] RFPC_CMD_EXT  = 5'h19;
  localparam logic [7:0] RFPC_RST_CHIP = 8'h01;
  localparam logic [7:0] RFPC_RST_PROT = 8'h02;
  localparam logic [7:0] RFPC_RST_HBR  = 8'h00;
  localparam logic [7:0] RFPC_RST_MOD  = 8'h11;
  localparam int         RFPC_CHIP_SEL = 1;
  localparam int         RFPC_CHIP_PWR = 4;
  localparam int         RFPC_PROT_NFC = 5;
  localparam int         RFPC_PROT_EMU = 2;
  localparam int         RFPC_PROT_DIR = 6;
  localparam int         RFPC_MOD_EXT  = 6;
  localparam int         RFPC_LVL_OSC  = 6;
  localparam int         RFPC_CLK_HZ   = 20000000;
  localparam int         RFPC_LP_HZ    = 60000;
  localparam int         RFPC_LP_HALF  = RFPC_CLK_HZ / (2 * RFPC_LP_HZ);
  localparam int         RFPC_PULSE_PS = 73700;
  localparam int         RFPC_CLK_PS   = 50000;
  localparam int         RFPC_PULSE_CYC =
    (RFPC_PULSE_PS + RFPC_CLK_PS - 1) / RFPC_CLK_PS;

  typedef enum logic [1:0] {
    RFPC_MS_IDLE = 2'b00,
    RFPC_MS_INT  = 2'b01,
    RFPC_MS_EXT  = 2'b10
  } rfpc_meas_e;

  typedef enum logic [3:0] {
    RFPC_P_VIC  = 4'h0,
    RFPC_P_A    = 4'h1,
    RFPC_P_B    = 4'h2,
    RFPC_P_CARD = 4'h3,
    RFPC_P_PEER = 4'h4,
    RFPC_P_EMUA = 4'h5,
    RFPC_P_EMUB = 4'h6,
    RFPC_P_NONE = 4'h7
  } rfpc_proto_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       cmd;
    logic [4:0] adr;
    logic [7:0] wdata;
  } rfpc_req_s;

  typedef struct packed {
    rfpc_proto_e family;
    logic [1:0]  rate;
    logic        vic_256;
    logic        vic_dbl;
    logic        rx_only;
    logic        valid;
  } rfpc_cfg_s;
endpackage : rfpc_pkg

// ===== rtl/rfpc_core.sv
// Protocol configuration, signal-strength capture and clock/modulation control.
// Assumes host requests arrive as one-cycle strobes on ref_clk_i.
`timescale 1ns/10ps
module rfpc_core #(
  parameter int PULSE_CYC = rfpc_pkg::RFPC_PULSE_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire rfpc_pkg::rfpc_req_s req_i,
  output logic [7:0]             rdata_o,
  output logic                   rvalid_o,
  input  wire logic [2:0]        main_level_i,
  input  wire logic [2:0]        aux_level_i,
  input  wire logic [2:0]        ext_level_i,
  input  wire logic              osc_ok_i,
  input  wire logic              tx_start_i,
  input  wire logic              enable_i,
  input  wire logic              secondary_wake_pin_i,
  input  wire logic              mod_type_pin_i,
  input  wire logic              tx_pulse_req_i,
  output logic                   buffered_clock_output_o,
  output logic                   full_power_o,
  output logic [2:0]             mod_depth_o,
  output logic                   ook_sel_o,
  output logic                   mod_pulse_o,
  output logic                   use_protocol_pulse_o,
  output rfpc_pkg::rfpc_cfg_s    cfg_o
);
  import rfpc_pkg::*;

  typedef struct packed {
    logic [7:0]  chip;
    logic [7:0]  prot;
    logic [7:0]  hbr;
    logic [7:0]  puls;
    logic [7:0]  modc;
    logic [2:0]  lvl_main;
    logic [2:0]  lvl_aux;
    rfpc_meas_e  meas;
    rfpc_cfg_s   cfg;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [1:0]  div;
    logic [15:0] lp_cnt;
    logic        lp_clk;
    logic [15:0] pcnt;
    logic        pulse;
    logic        ook;
    logic        use_proto;
    logic [1:0]  en_sync1;
    logic [1:0]  en_sync2;
    logic [1:0]  mp_sync;
  } rfpc_state_s;

  rfpc_state_s st_r;
  rfpc_state_s st_nxt;
  rfpc_cfg_s   dec;

  logic [2:0]  lvl_in   [2];
  logic [2:0]  lvl_held [2];
  logic [2:0]  lvl_peak [2];

  assign lvl_in[0]   = main_level_i;
  assign lvl_in[1]   = aux_level_i;
  assign lvl_held[0] = st_r.lvl_main;
  assign lvl_held[1] = st_r.lvl_aux;

  // Peak hold of the two identical internal receive paths.
  for (genvar g = 0; g < 2; g = g + 1) begin : g_peak
    assign lvl_peak[g] = (lvl_in[g] > lvl_held[g]) ? lvl_in[g] : lvl_held[g];
  end

  // Decodes a protocol register value into a configuration.
  function automatic rfpc_cfg_s decode(input logic [7:0] p, input logic [7:0] h);
    rfpc_cfg_s c;
    c = '{family: RFPC_P_NONE, rate: 2'b00, vic_256: 1'b0, vic_dbl: 1'b0,
          rx_only: 1'b0, valid: 1'b1};
    if (!p[RFPC_PROT_NFC]) begin
      case (p[4:0])
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07: begin
          c.family  = RFPC_P_VIC;
          c.vic_256 = p[0];
          c.rate    = {1'b0, p[1]};
          c.vic_dbl = p[2];
        end
        5'h08: begin
          c.family = RFPC_P_A;
          c.rate   = 2'b00;
        end
        5'h09: begin
          c.family = RFPC_P_A;
          c.rate   = 2'b01;
        end
        5'h0a: begin
          c.family = RFPC_P_A;
          c.rate   = 2'b10;
        end
        5'h0b: begin
          c.family = RFPC_P_A;
          c.rate   = 2'b11;
        end
        5'h0c: begin
          c.family = RFPC_P_B;
          c.rate   = 2'b00;
        end
        5'h0d: begin
          c.family = RFPC_P_B;
          c.rate   = 2'b01;
        end
        5'h0e: begin
          c.family = RFPC_P_B;
          c.rate   = 2'b10;
        end
        5'h0f: begin
          c.family = RFPC_P_B;
          c.rate   = 2'b11;
        end
        5'h1a: begin
          c.family = RFPC_P_CARD;
          c.rate   = 2'b10;
        end
        5'h1b: begin
          c.family = RFPC_P_CARD;
          c.rate   = 2'b11;
        end
        5'h13, 5'h14: begin
          c.valid = 1'b0;
        end
        default: begin
          c.valid = 1'b0;
        end
      endcase
      if ((c.family == RFPC_P_A || c.family == RFPC_P_B) && c.rate == 2'b01) begin
        c.rx_only = |h[1:0];
      end
    end else if (!p[RFPC_PROT_EMU]) begin
      c.family = RFPC_P_PEER;
      c.rate   = p[1:0];
      c.valid  = |p[1:0];
    end else begin
      c.family = p[0] ? RFPC_P_EMUB : RFPC_P_EMUA;
      c.valid  = !p[1];
    end
    return c;
  endfunction : decode

  always_comb begin
    st_nxt = st_r;
    dec    = decode(req_i.wdata, RFPC_RST_HBR);
    st_nxt.rvalid   = 1'b0;
    st_nxt.en_sync1 = {enable_i, secondary_wake_pin_i};
    st_nxt.en_sync2 = st_r.en_sync1;
    st_nxt.mp_sync  = {st_r.mp_sync[0], mod_type_pin_i};
    // Peak latching of the running measurement.
    case (st_r.meas)
      RFPC_MS_INT: begin
        if (!st_r.chip[RFPC_CHIP_SEL]) begin
          st_nxt.lvl_main = lvl_peak[0];
          st_nxt.lvl_aux  = lvl_peak[1];
        end
      end
      RFPC_MS_EXT: begin
        if (st_r.chip[RFPC_CHIP_SEL] && ext_level_i > st_r.lvl_main) begin
          st_nxt.lvl_main = ext_level_i;
        end
      end
      default: st_nxt.meas = RFPC_MS_IDLE;
    endcase
    if (tx_start_i) begin
      st_nxt.lvl_main = 3'h0;
      st_nxt.lvl_aux  = 3'h0;
    end
    if (req_i.cmd) begin
      case (req_i.adr)
        RFPC_CMD_INT: begin
          st_nxt.meas = RFPC_MS_INT;
        end
        RFPC_CMD_EXT: begin
          st_nxt.meas = RFPC_MS_EXT;
        end
        default: st_nxt.meas = st_r.meas;
      endcase
    end else if (req_i.wr) begin
      case (req_i.adr)
        RFPC_ADR_CHIP: begin
          st_nxt.chip = req_i.wdata;
        end
        RFPC_ADR_PROT: begin
          if (dec.valid) begin
            st_nxt.prot = req_i.wdata;
            st_nxt.cfg  = dec;
            st_nxt.hbr  = RFPC_RST_HBR;
            st_nxt.puls = 8'h00;
          end
        end
        RFPC_ADR_HBR: begin
          st_nxt.hbr = req_i.wdata;
          st_nxt.cfg = decode(st_r.prot, req_i.wdata);
        end
        RFPC_ADR_PULS: begin
          st_nxt.puls = req_i.wdata;
        end
        RFPC_ADR_MOD: begin
          st_nxt.modc = req_i.wdata;
        end
        default: begin
          st_nxt.chip = st_r.chip;
        end
      endcase
    end else if (req_i.rd) begin
      st_nxt.rvalid = 1'b1;
      case (req_i.adr)
        RFPC_ADR_CHIP: begin
          st_nxt.rdata = st_r.chip;
        end
        RFPC_ADR_PROT: begin
          st_nxt.rdata = st_r.prot;
        end
        RFPC_ADR_HBR: begin
          st_nxt.rdata = st_r.hbr;
        end
        RFPC_ADR_PULS: begin
          st_nxt.rdata = st_r.puls;
        end
        RFPC_ADR_MOD: begin
          st_nxt.rdata = st_r.modc;
        end
        RFPC_ADR_LVL: begin
          st_nxt.rdata = {1'b0, osc_ok_i, st_r.lvl_aux, st_r.lvl_main};
          if (!tx_start_i) begin
            st_nxt.lvl_main = 3'h0;
            st_nxt.lvl_aux  = 3'h0;
          end
          st_nxt.meas = RFPC_MS_IDLE;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
    // Clock output divider and low-power clock.
    st_nxt.div = st_r.div + 2'h1;
    if (st_r.lp_cnt == 16'(RFPC_LP_HALF - 1)) begin
      st_nxt.lp_cnt = 16'h0000;
      st_nxt.lp_clk = !st_r.lp_clk;
    end else begin
      st_nxt.lp_cnt = st_r.lp_cnt + 16'h0001;
    end
    // Pulse-length override.
    if (tx_pulse_req_i && st_r.puls != 8'h00 && !st_r.pulse) begin
      st_nxt.pulse = 1'b1;
      st_nxt.pcnt  = 16'(st_r.puls) * 16'(PULSE_CYC);
    end else if (st_r.pulse) begin
      if (st_r.pcnt <= 16'h0001) begin
        st_nxt.pulse = 1'b0;
        st_nxt.pcnt  = 16'h0000;
      end else begin
        st_nxt.pcnt = st_r.pcnt - 16'h0001;
      end
    end
    // Derived flags are registered together with the fields they follow.
    st_nxt.use_proto = (st_nxt.puls == 8'h00);
    if (st_nxt.prot[RFPC_PROT_DIR] && st_nxt.modc[RFPC_MOD_EXT]) begin
      st_nxt.ook = st_nxt.mp_sync[1];
    end else begin
      st_nxt.ook = (st_nxt.modc[2:0] == 3'h0);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.chip <= RFPC_RST_CHIP;
      st_r.prot <= RFPC_RST_PROT;
      st_r.hbr  <= RFPC_RST_HBR;
      st_r.modc <= RFPC_RST_MOD;
      st_r.meas <= RFPC_MS_IDLE;
      st_r.use_proto <= 1'b1;
      st_r.cfg  <= '{family: RFPC_P_VIC, rate: 2'b01, vic_256: 1'b0, vic_dbl: 1'b0,
                     rx_only: 1'b0, valid: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    if (!st_r.en_sync2[1] && st_r.en_sync2[0]) begin
      buffered_clock_output_o = st_r.lp_clk;
    end else begin
      case (st_r.modc[5:4])
        2'b00: buffered_clock_output_o = ref_clk_i;
        2'b01: buffered_clock_output_o = st_r.div[0];
        default: buffered_clock_output_o = st_r.div[1];
      endcase
    end
  end

  assign rdata_o              = st_r.rdata;
  assign rvalid_o             = st_r.rvalid;
  assign full_power_o         = st_r.chip[RFPC_CHIP_PWR];
  assign mod_depth_o          = st_r.modc[2:0];
  assign ook_sel_o            = st_r.ook;
  assign mod_pulse_o          = st_r.pulse;
  assign use_protocol_pulse_o = st_r.use_proto;
  assign cfg_o                = st_r.cfg;
endmodule : rfpc_core

// ===== tb/rfpc_core_properties.sv
// Port checker of the protocol configuration block.
// Assumes it is bound onto every rfpc_core instance.
`timescale 1ns/10ps
module rfpc_chk (
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire rfpc_pkg::rfpc_req_s req_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                rvalid_o,
  input wire logic                full_power_o,
  input wire logic [2:0]          mod_depth_o,
  input wire logic                use_protocol_pulse_o,
  input wire rfpc_pkg::rfpc_cfg_s cfg_o
);
  import rfpc_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic wr;
  assign rd = req_i.rd && !req_i.cmd && !req_i.wr;
  assign wr = req_i.wr && !req_i.cmd;
  a_read_answer: assert property (rd |=> rvalid_o)
    else $error("read not answered");
  a_valid_cause: assert property (!rd |=> !rvalid_o)
    else $error("read valid without read");
  a_level_read_clears: assert property (
    rd && req_i.adr == RFPC_ADR_LVL ##2 rd && req_i.adr == RFPC_ADR_LVL
    |=> rdata_o[5:0] == 6'h00) else $error("level not cleared by read");
  a_depth_follows: assert property (wr && req_i.adr == RFPC_ADR_MOD
    |=> mod_depth_o == $past(req_i.wdata[2:0])) else $error("depth wrong");
  a_power_follows: assert property (wr && req_i.adr == RFPC_ADR_CHIP
    |=> full_power_o == $past(req_i.wdata[4])) else $error("power wrong");
  a_pulse_select: assert property (wr && req_i.adr == RFPC_ADR_PULS
    |=> use_protocol_pulse_o == ($past(req_i.wdata) == 8'h00)) else $error("pulse sel");
  a_prot_preset: assert property (wr && req_i.adr == RFPC_ADR_PROT
    && req_i.wdata[5:0] == 6'h08 |=> use_protocol_pulse_o ##[0:1] cfg_o.family == RFPC_P_A)
    else $error("protocol preset wrong");
  a_reserved_keep: assert property (wr && req_i.adr == RFPC_ADR_PROT
    && req_i.wdata[5:0] == 6'h13 |-> ##2 cfg_o == $past(cfg_o, 2)) else $error("reserved");
  c_level_read: cover property (rd && req_i.adr == RFPC_ADR_LVL);
  c_ext_meas: cover property (req_i.cmd && req_i.adr == RFPC_CMD_EXT);
  c_prot_write: cover property (wr && req_i.adr == RFPC_ADR_PROT);
endmodule : rfpc_chk
bind rfpc_core rfpc_chk i_rfpc_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .full_power_o(full_power_o),
  .mod_depth_o(mod_depth_o), .use_protocol_pulse_o(use_protocol_pulse_o), .cfg_o(cfg_o));

// ===== tb/rfpc_host.sv
// Host model issuing one-cycle register and command strobes.
// Assumes read data is settled one cycle after the strobe.
`timescale 1ns/10ps
module rfpc_host (
  input  wire logic          ref_clk_i,
  input  wire logic [7:0]    rdata_i,
  output rfpc_pkg::rfpc_req_s req_o
);
  import rfpc_pkg::*;
  initial req_o = '0;
  // Kind 0 writes, 1 reads, 2 commands; released lines show inverted values.
  task automatic acc(input int k, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge ref_clk_i);
    req_o = '{wr: k == 0, rd: k == 1, cmd: k == 2, adr: a, wdata: d};
    @(negedge ref_clk_i);
    q = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, cmd: 1'b0, adr: ~a, wdata: ~d};
  endtask : acc
endmodule : rfpc_host

// ===== tb/test_rfpc_core.sv
// Self-checking bench of the protocol configuration block.
// Assumes the host model and the bound port checker.
`timescale 1ns/10ps
module test_rfpc_core;
  import rfpc_pkg::*;
  logic       ref_clk_i = 0, rst_i = 1, txs = 0, en = 1, wake = 0, mpin = 0, preq = 0, osc = 1;
  logic [2:0] ml = 0, al = 0, el = 0, md;
  logic [7:0] q, rq;
  logic       rv, bclk, fp, ook, mp, upp;
  rfpc_req_s  req;
  rfpc_cfg_s  cfg;
  int         n_errors = 0, checked = 0, nr = 0, n;
  logic [7:0]  pc[11] = '{8'h02, 8'h08, 8'h0c, 8'h1a, 8'h1b, 8'h13, 8'h21, 8'h20, 8'h24,
                          8'h25, 8'h26};
  rfpc_proto_e pf[11] = '{RFPC_P_VIC, RFPC_P_A, RFPC_P_B, RFPC_P_CARD, RFPC_P_CARD,
    RFPC_P_CARD, RFPC_P_PEER, RFPC_P_PEER, RFPC_P_EMUA, RFPC_P_EMUB, RFPC_P_EMUB};
  logic [7:0]  dm[4] = '{8'h01, 8'h11, 8'h21, 8'h37};
  logic [7:0]  dv[4] = '{8'h10, 8'h08, 8'h04, 8'h04};
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge bclk) nr++;
  rfpc_core #(.PULSE_CYC(2)) i_rfpc_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rq), .rvalid_o(rv), .main_level_i(ml), .aux_level_i(al), .ext_level_i(el),
    .osc_ok_i(osc), .tx_start_i(txs), .enable_i(en), .secondary_wake_pin_i(wake),
    .mod_type_pin_i(mpin), .tx_pulse_req_i(preq), .buffered_clock_output_o(bclk),
    .full_power_o(fp), .mod_depth_o(md), .ook_sel_o(ook), .mod_pulse_o(mp),
    .use_protocol_pulse_o(upp), .cfg_o(cfg));
  rfpc_host i_rfpc_host (.ref_clk_i(ref_clk_i), .rdata_i(rq), .req_o(req));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_rfpc_host.acc(0, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    i_rfpc_host.acc(1, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    #(12000 * 50);
    n_errors++;
    end_sim();
  end
  initial begin
    cyc(5);
    rst_i = 0;
    rd(RFPC_ADR_CHIP, RFPC_RST_CHIP);
    rd(RFPC_ADR_PROT, RFPC_RST_PROT);
    rd(RFPC_ADR_MOD, RFPC_RST_MOD);
    rd(5'h05, 8'h00);
    foreach (pc[i]) begin
      wr(RFPC_ADR_PROT, pc[i]);
      cyc(3);
      chk({4'h0, cfg.family}, {4'h0, pf[i]});
    end
    wr(RFPC_ADR_PROT, 8'h09);
    wr(RFPC_ADR_HBR, 8'h01);
    cyc(3);
    chk({7'h00, cfg.rx_only}, 8'h01);
    wr(RFPC_ADR_PULS, 8'h03);
    preq = 1;
    n = 0;
    repeat (20) begin
      cyc(1);
      preq = 0;
      n += int'(mp);
    end
    chk(n[7:0], 8'h06);
    wr(RFPC_ADR_PROT, 8'h02);
    rd(RFPC_ADR_PULS, 8'h00);
    wr(RFPC_ADR_CHIP, 8'h31);
    chk({7'h00, fp}, 8'h01);
    ml = 3'h5;
    al = 3'h3;
    i_rfpc_host.acc(2, RFPC_CMD_INT, 8'h00, q);
    cyc(1000);
    rd(RFPC_ADR_LVL, 8'h5d);
    rd(RFPC_ADR_LVL, 8'h40);
    i_rfpc_host.acc(2, RFPC_CMD_INT, 8'h00, q);
    cyc(3);
    ml = 0;
    al = 0;
    txs = 1;
    cyc(1);
    txs = 0;
    osc = 0;
    rd(RFPC_ADR_LVL, 8'h00);
    osc = 1;
    wr(RFPC_ADR_CHIP, 8'h03);
    el = 3'h6;
    i_rfpc_host.acc(2, RFPC_CMD_EXT, 8'h00, q);
    cyc(1000);
    rd(RFPC_ADR_LVL, 8'h46);
    foreach (dm[i]) begin
      wr(RFPC_ADR_MOD, dm[i]);
      cyc(2);
      nr = 0;
      cyc(16);
      chk(nr[7:0], dv[i]);
    end
    en = 0;
    wake = 1;
    cyc(400);
    nr = 0;
    cyc(664);
    chk(nr[7:0], 8'h02);
    en = 1;
    wake = 0;
    wr(RFPC_ADR_PROT, 8'h42);
    wr(RFPC_ADR_MOD, 8'h51);
    mpin = 1;
    cyc(4);
    chk({7'h00, ook}, 8'h01);
    wr(RFPC_ADR_MOD, 8'h11);
    cyc(4);
    chk({7'h00, ook}, 8'h00);
    end_sim();
  end
endmodule : test_rfpc_core
